// >>> hw/solsr_bus_if.sv
// carrier between the serial port and the register bank
`timescale 1ns/1ps
`default_nettype none
interface solsr_bus_if;
   logic [31:0] word;
   logic        word_valid;
   logic [31:0] status_word;
   logic        rb_active;
   logic        rb_bit;
   logic        rb_done;
   modport port (output word, word_valid, rb_active, rb_bit, rb_done, input status_word);
   modport regs (input word, word_valid, rb_active, rb_bit, rb_done, output status_word);
endinterface
`default_nettype wire

// >>> hw/solsr_pkg.sv
// constants and helpers for the synthesizer output, lock and status register bank
// Functional notes
// - bits 7:6 select secondary output power
// - bit 5 enables primary RF output
// - bits 4:3 select primary output power
// - address 100 loads output-stage word
// - address 101 lock word, reset 00400005h
// - bit 24 forces integer mode at zero fraction
// - bits 23:22 pick lock pin function
// - bit 18 is test pin select MSB
// - address 110 status word is read-only
// - status bit 23 set until readback done
// - status bits 22:20 carry tuning reading
// - status bits 8:3 carry active core index
// - status bits 2:0 read back 110
// - status shifted out during host readback
package solsr_pkg;
   localparam int          WORD_W           = 32;
   localparam int          ADDR_W           = 3;
   localparam int          PWR_W            = 2;
   localparam int          TUNE_W           = 3;
   localparam int          CORE_W           = 6;
   localparam int          SEL_LOW_W        = 3;
   localparam int          DBM_W            = 4;
   localparam logic [2:0]  ADDR_OUT_STAGE   = 3'h4;
   localparam logic [2:0]  ADDR_LOCK_MODE   = 3'h5;
   localparam logic [2:0]  ADDR_STATUS      = 3'h6;
   localparam int          OUT_SEC_PWR_LSB  = 6;
   localparam int          OUT_PRI_EN_BIT   = 5;
   localparam int          OUT_PRI_PWR_LSB  = 3;
   localparam int          LOCK_INT_SEL_BIT = 24;
   localparam int          LOCK_PIN_LSB     = 22;
   localparam int          LOCK_SEL_MSB_BIT = 18;
   localparam int          ST_FRESH_BIT     = 23;
   localparam int          ST_TUNE_LSB      = 20;
   localparam int          ST_CORE_LSB      = 3;
   localparam logic [31:0] OUT_STAGE_RESET  = 32'h0000_0004;
   localparam logic [31:0] LOCK_MODE_RESET  = 32'h0040_0005;
   localparam logic [1:0]  LOCK_PIN_LOW     = 2'h0;
   localparam logic [1:0]  LOCK_PIN_DIGITAL = 2'h1;
   localparam logic [1:0]  LOCK_PIN_ANALOG  = 2'h2;
   localparam logic [1:0]  LOCK_PIN_HIGH    = 2'h3;
   localparam logic [5:0]  RB_LAST_IDX      = 6'h1F;

   // power code to signed dBm: -4, -1, +2, +5
   function automatic logic signed [3:0] power_dbm(input logic [1:0] code);
      logic signed [3:0] dbm;
      dbm = 4'sh0;
      unique case (code)
         2'h0: dbm = -4'sd4;
         2'h1: dbm = -4'sd1;
         2'h2: dbm = 4'sd2;
         2'h3: dbm = 4'sd5;
      endcase
      return dbm;
   endfunction
endpackage

// >>> hw/solsr_serial.sv
// serial shifter: word capture at load edge and status readback shift-out
`timescale 1ns/1ps
`default_nettype none
module solsr_serial (
   // clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        resetn_i,
   // serial pins
   input  wire logic        ser_clk_i,
   input  wire logic        ser_data_i,
   input  wire logic        ser_le_i,
   // to register bank
   solsr_bus_if.port        bus
);
   typedef enum logic {SOLSR_RB_IDLE, SOLSR_RB_SHIFT} solsr_rb_state_t;

   solsr_rb_state_t state_reg, state_next;
   logic        sclk_q_reg, sclk_q_next;
   logic        le_q_reg,   le_q_next;
   logic [31:0] shift_reg,  shift_next;
   logic [31:0] word_reg,   word_next;
   logic        valid_reg,  valid_next;
   logic [31:0] rb_reg,     rb_next;
   logic [5:0]  cnt_reg,    cnt_next;
   logic        done_reg,   done_next;
   logic        sclk_rise;
   logic        le_rise;

   always_comb begin
      sclk_rise   = ser_clk_i & ~sclk_q_reg;
      le_rise     = ser_le_i & ~le_q_reg;
      sclk_q_next = ser_clk_i;
      le_q_next   = ser_le_i;
      shift_next  = shift_reg;
      // bits shifted while load enable is low, msb first
      if (sclk_rise && !ser_le_i) begin
         shift_next = {shift_reg[30:0], ser_data_i};
      end
      valid_next = le_rise;
      word_next  = le_rise ? shift_reg : word_reg;
      state_next = state_reg;
      rb_next    = rb_reg;
      cnt_next   = cnt_reg;
      done_next  = 1'b0;
      unique case (state_reg)
         SOLSR_RB_IDLE: begin
            // status snapshot taken at the load edge, so the word is coherent
            if (le_rise && shift_reg[2:0] == solsr_pkg::ADDR_STATUS) begin
               rb_next    = bus.status_word;
               cnt_next   = '0;
               state_next = SOLSR_RB_SHIFT;
            end
         end
         SOLSR_RB_SHIFT: begin
            // load edges during a readback are not rescanned for another readback
            if (sclk_rise) begin
               rb_next  = {rb_reg[30:0], 1'b0};
               cnt_next = cnt_reg + 6'h1;
               if (cnt_reg == solsr_pkg::RB_LAST_IDX) begin
                  state_next = SOLSR_RB_IDLE;
                  done_next  = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         state_reg  <= SOLSR_RB_IDLE;
         sclk_q_reg <= 1'b0;
         le_q_reg   <= 1'b0;
         shift_reg  <= '0;
         word_reg   <= '0;
         valid_reg  <= 1'b0;
         rb_reg     <= '0;
         cnt_reg    <= '0;
         done_reg   <= 1'b0;
      end else begin
         state_reg  <= state_next;
         sclk_q_reg <= sclk_q_next;
         le_q_reg   <= le_q_next;
         shift_reg  <= shift_next;
         word_reg   <= word_next;
         valid_reg  <= valid_next;
         rb_reg     <= rb_next;
         cnt_reg    <= cnt_next;
         done_reg   <= done_next;
      end
   end

   assign bus.word       = word_reg;
   assign bus.word_valid = valid_reg;
   assign bus.rb_active  = (state_reg == SOLSR_RB_SHIFT);
   assign bus.rb_bit     = rb_reg[31];
   assign bus.rb_done    = done_reg;

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);

   sequence s_rb_request;
      le_rise && shift_reg[2:0] == solsr_pkg::ADDR_STATUS && state_reg == SOLSR_RB_IDLE;
   endsequence
   sequence s_rb_first_bit;
      bus.rb_active && rb_reg == $past(bus.status_word);
   endsequence

   chk_rb_start_bit: assert property (s_rb_request |=> s_rb_first_bit)
      else $error("readback did not start with status msb");
   chk_word_capture: assert property (le_rise |=> valid_reg && word_reg == $past(shift_reg))
      else $error("word not captured at load edge");
   chk_rb_shift_step: assert property (bus.rb_active && sclk_rise && cnt_reg != solsr_pkg::RB_LAST_IDX
      |=> bus.rb_active && bus.rb_bit == $past(rb_reg[30]))
      else $error("readback bit did not advance");
endmodule
`default_nettype wire

// >>> hw/solsr_top.sv
// register bank for output stage, lock and mode, and status readback
`timescale 1ns/1ps
`default_nettype none
module solsr_top (
   // clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       resetn_i,
   // serial control pins
   input  wire logic       ser_clk_i,
   input  wire logic       ser_data_i,
   input  wire logic       ser_le_i,
   // synthesizer state
   input  wire logic       dig_lock_i,
   input  wire logic       ana_lock_i,
   input  wire logic       frac_zero_i,
   input  wire logic [2:0] test_sel_low_i,
   input  wire logic       test_fn_i,
   input  wire logic [2:0] tuning_voltage_reading_i,
   input  wire logic [5:0] active_core_i,
   // output stage controls
   output logic            primary_output_enable_o,
   output logic [1:0]      primary_output_power_o,
   output logic [1:0]      secondary_output_power_o,
   output logic [3:0]      primary_power_dbm_o,
   output logic [3:0]      secondary_power_dbm_o,
   // lock and mode
   output logic            int_mode_o,
   output logic            lock_detect_pin_o,
   output logic [3:0]      test_pin_select_o,
   output logic            multiplexed_test_pin_o
);
   solsr_bus_if bus ();

   solsr_serial u_serial (
      .clk_sys_i  (clk_sys_i),
      .resetn_i   (resetn_i),
      .ser_clk_i  (ser_clk_i),
      .ser_data_i (ser_data_i),
      .ser_le_i   (ser_le_i),
      .bus        (bus.port)
   );

   logic [31:0] out_stage_reg, out_stage_next;
   logic [31:0] lock_mode_reg, lock_mode_next;
   logic        fresh_reg,     fresh_next;
   logic [2:0]  wr_addr;
   logic [1:0]  lock_detect_select;
   logic        zero_fraction_integer_select;
   logic        test_pin_select_msb;
   logic [1:0]  primary_output_power;
   logic [1:0]  secondary_output_power;

   // register writes and defaults flag
   always_comb begin
      wr_addr        = bus.word[solsr_pkg::ADDR_W-1:0];
      out_stage_next = out_stage_reg;
      lock_mode_next = lock_mode_reg;
      fresh_next     = fresh_reg;
      if (bus.word_valid) begin
         unique case (wr_addr)
            solsr_pkg::ADDR_OUT_STAGE: out_stage_next = bus.word;
            solsr_pkg::ADDR_LOCK_MODE: lock_mode_next = bus.word;
            // reserved lock bits are stored as written; host keeps them zero
            default: ;
         endcase
      end
      // only reset sets the flag, so no set and clear can collide
      if (bus.rb_done) begin
         fresh_next = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         out_stage_reg <= solsr_pkg::OUT_STAGE_RESET;
         lock_mode_reg <= solsr_pkg::LOCK_MODE_RESET;
         fresh_reg     <= 1'b1;
      end else begin
         out_stage_reg <= out_stage_next;
         lock_mode_reg <= lock_mode_next;
         fresh_reg     <= fresh_next;
      end
   end

   // field views
   always_comb begin
      secondary_output_power = out_stage_reg[solsr_pkg::OUT_SEC_PWR_LSB +: solsr_pkg::PWR_W];
      primary_output_power   = out_stage_reg[solsr_pkg::OUT_PRI_PWR_LSB +: solsr_pkg::PWR_W];
      lock_detect_select     = lock_mode_reg[solsr_pkg::LOCK_PIN_LSB +: 2];
      zero_fraction_integer_select = lock_mode_reg[solsr_pkg::LOCK_INT_SEL_BIT];
      test_pin_select_msb    = lock_mode_reg[solsr_pkg::LOCK_SEL_MSB_BIT];
   end

   // status word, live; the serial side snapshots it at the readback request
   always_comb begin
      bus.status_word = '0;
      bus.status_word[solsr_pkg::ST_FRESH_BIT] = fresh_reg;
      bus.status_word[solsr_pkg::ST_TUNE_LSB +: solsr_pkg::TUNE_W] =
         tuning_voltage_reading_i;
      bus.status_word[solsr_pkg::ST_CORE_LSB +: solsr_pkg::CORE_W] = active_core_i;
      bus.status_word[solsr_pkg::ADDR_W-1:0] = solsr_pkg::ADDR_STATUS;
   end

   // output flops
   logic       pri_en_next;
   logic [1:0] pri_pwr_next;
   logic [1:0] sec_pwr_next;
   logic [3:0] pri_dbm_next;
   logic [3:0] sec_dbm_next;
   logic       int_mode_next;
   logic       lock_pin_next;
   logic [3:0] test_sel_next;
   logic       test_pin_next;

   always_comb begin
      pri_en_next   = out_stage_reg[solsr_pkg::OUT_PRI_EN_BIT];
      pri_pwr_next  = primary_output_power;
      sec_pwr_next  = secondary_output_power;
      pri_dbm_next  = solsr_pkg::power_dbm(primary_output_power);
      sec_dbm_next  = solsr_pkg::power_dbm(secondary_output_power);
      int_mode_next = frac_zero_i & zero_fraction_integer_select;
      lock_pin_next = 1'b0;
      unique case (lock_detect_select)
         solsr_pkg::LOCK_PIN_LOW:     lock_pin_next = 1'b0;
         solsr_pkg::LOCK_PIN_DIGITAL: lock_pin_next = dig_lock_i;
         solsr_pkg::LOCK_PIN_ANALOG:  lock_pin_next = ana_lock_i;
         solsr_pkg::LOCK_PIN_HIGH:    lock_pin_next = 1'b1;
      endcase
      test_sel_next = {test_pin_select_msb, test_sel_low_i};
      // readback owns the pin for its duration
      test_pin_next = bus.rb_active ? bus.rb_bit : test_fn_i;
   end

   always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
         primary_output_enable_o  <= 1'b0;
         primary_output_power_o   <= '0;
         secondary_output_power_o <= '0;
         primary_power_dbm_o      <= '0;
         secondary_power_dbm_o    <= '0;
         int_mode_o               <= 1'b0;
         lock_detect_pin_o        <= 1'b0;
         test_pin_select_o        <= '0;
         multiplexed_test_pin_o   <= 1'b0;
      end else begin
         primary_output_enable_o  <= pri_en_next;
         primary_output_power_o   <= pri_pwr_next;
         secondary_output_power_o <= sec_pwr_next;
         primary_power_dbm_o      <= pri_dbm_next;
         secondary_power_dbm_o    <= sec_dbm_next;
         int_mode_o               <= int_mode_next;
         lock_detect_pin_o        <= lock_pin_next;
         test_pin_select_o        <= test_sel_next;
         multiplexed_test_pin_o   <= test_pin_next;
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!resetn_i);

   sequence s_write(logic [2:0] a);
      bus.word_valid && wr_addr == a;
   endsequence

   chk_out_stage_load: assert property (s_write(solsr_pkg::ADDR_OUT_STAGE)
      |=> out_stage_reg == $past(bus.word)
      ##1 primary_output_enable_o == $past(bus.word[solsr_pkg::OUT_PRI_EN_BIT], 2))
      else $error("output-stage word not loaded");
   chk_lock_mode_load: assert property (s_write(solsr_pkg::ADDR_LOCK_MODE)
      |=> lock_mode_reg == $past(bus.word) && $stable(out_stage_reg))
      else $error("lock word load wrong");
   chk_status_readonly: assert property (s_write(solsr_pkg::ADDR_STATUS)
      |=> $stable(out_stage_reg) && $stable(lock_mode_reg) && $stable(fresh_reg))
      else $error("status write altered state");
   chk_power_decode: assert property (secondary_output_power == 2'h3
      |=> $signed(secondary_power_dbm_o) == 4'sd5)
      else $error("secondary power decode wrong");
   chk_pri_power_low: assert property (primary_output_power == 2'h0
      |=> $signed(primary_power_dbm_o) == -4'sd4 && primary_output_power_o == 2'h0)
      else $error("primary power decode wrong");
   chk_lock_pin_fn: assert property (lock_detect_select == solsr_pkg::LOCK_PIN_DIGITAL
      |=> lock_detect_pin_o == $past(dig_lock_i))
      else $error("lock pin not following digital lock");
   chk_lock_pin_high: assert property (lock_detect_select == solsr_pkg::LOCK_PIN_HIGH
      |=> lock_detect_pin_o)
      else $error("lock pin not high");
   chk_int_mode: assert property (##1
      int_mode_o == $past(frac_zero_i && lock_mode_reg[solsr_pkg::LOCK_INT_SEL_BIT]))
      else $error("integer mode select wrong");
   chk_sel_msb: assert property (##1 test_pin_select_o[solsr_pkg::SEL_LOW_W]
      == $past(lock_mode_reg[solsr_pkg::LOCK_SEL_MSB_BIT]))
      else $error("test pin select msb wrong");
   chk_fresh_clear: assert property (bus.rb_done
      |=> !fresh_reg ##1 !bus.status_word[solsr_pkg::ST_FRESH_BIT])
      else $error("defaults flag not cleared by readback");
   chk_status_fields: assert property (
      bus.status_word[solsr_pkg::ADDR_W-1:0] == solsr_pkg::ADDR_STATUS
      && bus.status_word[solsr_pkg::ST_CORE_LSB +: solsr_pkg::CORE_W] == active_core_i
      && bus.status_word[solsr_pkg::ST_TUNE_LSB +: solsr_pkg::TUNE_W] == tuning_voltage_reading_i
      && bus.status_word[solsr_pkg::ST_FRESH_BIT] == fresh_reg)
      else $error("status word fields wrong");
   chk_pin_readback: assert property (bus.rb_active |=> multiplexed_test_pin_o == $past(bus.rb_bit))
      else $error("readback bit missing from test pin");
   chk_pin_normal: assert property (!bus.rb_active
      |=> multiplexed_test_pin_o == $past(test_fn_i))
      else $error("test pin not following its normal function");
   chk_pri_enable: assert property (##1
      primary_output_enable_o == $past(out_stage_reg[solsr_pkg::OUT_PRI_EN_BIT]))
      else $error("primary output enable wrong");
   chk_sec_power_low: assert property (secondary_output_power == 2'h0
      |=> $signed(secondary_power_dbm_o) == -4'sd4)
      else $error("secondary power low decode wrong");
   chk_sec_power_one: assert property (secondary_output_power == 2'h1
      |=> $signed(secondary_power_dbm_o) == -4'sd1)
      else $error("secondary power second step wrong");
   chk_pri_power_mid: assert property (primary_output_power == 2'h2
      |=> $signed(primary_power_dbm_o) == 4'sd2)
      else $error("primary power third step wrong");
   chk_lock_pin_low: assert property (lock_detect_select == solsr_pkg::LOCK_PIN_LOW
      |=> !lock_detect_pin_o)
      else $error("lock pin not low");
   chk_lock_pin_ana: assert property (lock_detect_select == solsr_pkg::LOCK_PIN_ANALOG
      |=> lock_detect_pin_o == $past(ana_lock_i))
      else $error("lock pin not following analog lock");
endmodule
`default_nettype wire

// >>> verif/solsr_host.sv
// host-side serial driver and status readback sampler
`timescale 1ns/1ps
`default_nettype none
module solsr_host (
   // clock
   input  wire logic clk_sys_i,
   // serial pins
   output logic      ser_clk_o,
   output logic      ser_data_o,
   output logic      ser_le_o,
   input  wire logic mux_pin_i
);
   initial begin
      ser_clk_o  = 1'b0;
      ser_data_o = 1'b0;
      ser_le_o   = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask

   // msb first; gap stretches clock low time to act as a slow host
   task automatic write_word(input logic [31:0] w, input int gap);
      logic [31:0] v;
      v = w;
      if (w[2:0] == 3'h5) v = w & 32'h01C4_0007;
      for (int i = 31; i >= 0; i--) begin
         tick(1);
         ser_data_o = v[i];
         tick(1 + gap);
         ser_clk_o = 1'b1;
         tick(1);
         ser_clk_o = 1'b0;
      end
      // data line no longer meaningful: show the inverse
      ser_data_o = ~v[0];
      tick(1);
      ser_le_o = 1'b1;
      tick(1);
      ser_le_o = 1'b0;
   endtask

   // bit 31 shows before any clock rise, each rise brings the next
   task automatic read_word(input logic [31:0] cmd, output logic [31:0] w);
      write_word({cmd[31:3], 3'h6}, 0);
      tick(2);
      w[31] = mux_pin_i;
      for (int i = 30; i >= 0; i--) begin
         tick(1);
         ser_clk_o = 1'b1;
         tick(1);
         ser_clk_o = 1'b0;
         tick(2);
         w[i] = mux_pin_i;
      end
      // the last rise ends the readback
      tick(1);
      ser_clk_o = 1'b1;
      tick(1);
      ser_clk_o = 1'b0;
      tick(3);
   endtask
endmodule
`default_nettype wire

// >>> verif/solsr_top_tb.sv
// self-checking bench for the output, lock and status register bank
`timescale 1ns/1ps
`default_nettype none
module solsr_top_tb;
   logic        clk_sys_i;
   logic        resetn_i;
   logic        ser_clk, ser_data, ser_le;
   logic        dig_lock, ana_lock, frac_zero, test_fn;
   logic [2:0]  sel_low, tune;
   logic [5:0]  core;
   logic        pri_en, int_mode, lock_pin, mux_pin;
   logic [1:0]  pri_pwr, sec_pwr;
   logic [3:0]  pri_dbm, sec_dbm, sel;
   logic [7:0]  lfsr;
   logic [31:0] w, rb;
   int          m_out, m_lock, m_fresh;
   int          fail_count, checked;
   logic [31:0] exp_q [$];

   solsr_top u_solsr_top (
      .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
      .ser_clk_i(ser_clk), .ser_data_i(ser_data), .ser_le_i(ser_le),
      .dig_lock_i(dig_lock), .ana_lock_i(ana_lock), .frac_zero_i(frac_zero),
      .test_sel_low_i(sel_low), .test_fn_i(test_fn),
      .tuning_voltage_reading_i(tune), .active_core_i(core),
      .primary_output_enable_o(pri_en), .primary_output_power_o(pri_pwr),
      .secondary_output_power_o(sec_pwr), .primary_power_dbm_o(pri_dbm),
      .secondary_power_dbm_o(sec_dbm), .int_mode_o(int_mode),
      .lock_detect_pin_o(lock_pin), .test_pin_select_o(sel),
      .multiplexed_test_pin_o(mux_pin));

   solsr_host u_solsr_host (
      .clk_sys_i(clk_sys_i), .ser_clk_o(ser_clk), .ser_data_o(ser_data),
      .ser_le_o(ser_le), .mux_pin_i(mux_pin));

   always #12.5 clk_sys_i = ~clk_sys_i;

   function automatic logic [7:0] rnd();
      lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      return lfsr;
   endfunction

   function automatic logic [3:0] dbm_of(input logic [1:0] c);
      logic [3:0] t [4];
      t = '{4'hC, 4'hF, 4'h2, 4'h5};
      return t[c];
   endfunction

   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask

   task automatic end_of_test();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %s exp %h got %h", what, e, g);
      end
   endtask

   task automatic check_pins();
      logic lock_e;
      case (m_lock[23:22])
         2'h0: lock_e = 1'b0;
         2'h1: lock_e = dig_lock;
         2'h2: lock_e = ana_lock;
         default: lock_e = 1'b1;
      endcase
      cmp("pri_en", m_out[5], pri_en);
      cmp("pri_pwr", m_out[4:3], pri_pwr);
      cmp("sec_pwr", m_out[7:6], sec_pwr);
      cmp("pri_dbm", dbm_of(m_out[4:3]), pri_dbm);
      cmp("sec_dbm", dbm_of(m_out[7:6]), sec_dbm);
      cmp("int_mode", frac_zero & m_lock[24], int_mode);
      cmp("lock_pin", lock_e, lock_pin);
      cmp("sel", {m_lock[18], sel_low}, sel);
      cmp("mux_pin", test_fn, mux_pin);
   endtask

   // new synthesizer state, then time for registered outputs to follow
   task automatic shake();
      tick(1);
      {dig_lock, ana_lock, frac_zero, test_fn, sel_low, tune[0]} = rnd();
      {tune[2:1], core} = rnd();
      tick(3);
   endtask

   task automatic apply_reset();
      resetn_i = 1'b0;
      tick(2);
      resetn_i = 1'b1;
      m_out = 32'h0000_0004;
      m_lock = 32'h0040_0005;
      m_fresh = 1;
      tick(3);
      check_pins();
   endtask

   // reserved status bits are left unchecked
   task automatic readback();
      logic [31:0] e;
      shake();
      e = {8'h00, m_fresh[0], tune, 11'h000, core, 3'h6};
      exp_q.push_back(e & 32'h00F0_01FF);
      u_solsr_host.read_word({rnd(), rnd(), rnd(), rnd()}, rb);
      cmp("status", exp_q.pop_front(), rb & 32'h00F0_01FF);
      m_fresh = 0;
      check_pins();
   endtask

   initial begin
      clk_sys_i = 1'b0;
      resetn_i = 1'b0;
      {dig_lock, ana_lock, frac_zero, test_fn, sel_low, tune, core} = 16'h0000;
      fail_count = 0;
      checked = 0;
      lfsr = 8'h4A;
      apply_reset();
      for (int i = 0; i < 8; i++) begin
         w = {rnd(), rnd(), rnd(), 8'h00};
         w[7:3] = {i[1:0], i[2], ~i[1:0]};
         w[2:0] = 3'h4;
         u_solsr_host.write_word(w, i % 2);
         m_out = w;
         shake();
         check_pins();
      end
      for (int i = 0; i < 16; i++) begin
         w = {rnd(), rnd(), rnd(), rnd()};
         w[24] = i[2];
         w[23:22] = i[1:0];
         w[18] = i[3];
         w[2:0] = 3'h5;
         u_solsr_host.write_word(w, 0);
         m_lock = w & 32'h01C4_0007;
         shake();
         frac_zero = i[3];
         tick(3);
         check_pins();
      end
      // addresses outside the bank must load nothing
      for (int a = 0; a < 8; a++) begin
         if (a < 4 || a == 7) begin
            w = {rnd(), rnd(), rnd(), rnd()};
            w[2:0] = a[2:0];
            u_solsr_host.write_word(w, 0);
            shake();
            check_pins();
         end
      end
      readback();
      readback();
      apply_reset();
      readback();
      end_of_test();
   end

   initial begin
      for (int c = 0; c < 90000; c++) @(posedge clk_sys_i);
      fail_count++;
      end_of_test();
   end
endmodule
`default_nettype wire
